// ==== hdl/fpe_pkg.sv ====
// Constants, register map and field layout of the flash command block.
// Assumes a 32-bit AHB-Lite slave port clocked by core_clk at 200 MHz.
// Overview of operation
// R01: Erase bit starts erase of addressed page
// R02: Writing zero leaves command bits unchanged
// R03: Erase bit reads one until erase done
// R04: Erase may last up to 25 ms
// R05: Program bit writes data word at address
// R06: Program bit reads one until program done
// R07: Program may last up to 50 us
// R08: Interrupt only when raw and mask set
// R09: Raw bit 1 sets on cycle completion
// R10: Raw bit 0 sets on protection violation
// R11: Mask bits 1 and 0 gate sources
// R12: Masked bit is raw AND mask
// R13: Write one clears masked and raw bit; code clears the raw bit only while its mask bit is set
// R14: Software writes key with one command bit
// R15: Software supplies aligned addresses
// R16: Interrupt is OR; raw writes ignored
// R17: Reserved interrupt bits read zero
package fpe_pkg;
	localparam logic [11:0] ADDR_OFS     = 12'h000;
	localparam logic [11:0] WDATA_OFS    = 12'h004;
	localparam logic [11:0] CMD_OFS      = 12'h008;
	localparam logic [11:0] RAW_OFS      = 12'h00c;
	localparam logic [11:0] MASK_OFS     = 12'h010;
	localparam logic [11:0] MISC_OFS     = 12'h014;
	localparam logic [15:0] ACCESS_KEY   = 16'ha442;
	localparam int          PROG_BIT     = 0;
	localparam int          ERASE_BIT    = 1;
	localparam int          DONE_BIT     = 1;
	localparam int          VIOL_BIT     = 0;
	localparam logic [31:0] REG_RESET    = 32'h0000_0000;
	localparam logic [1:0]  IRQ_RESET    = 2'h0;
	localparam int          CLK_MHZ      = 200;
	localparam int          ERASE_MS     = 25;
	localparam int          PROG_US      = 50;
	localparam int          ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
	localparam int          PROG_CYCLES  = PROG_US * CLK_MHZ;
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} fpe_state_t;
endpackage : fpe_pkg

// ==== hdl/fpe_busy_timer.sv ====
// Down-counter that times one flash operation and pulses when done.
// Assumes the flash array needs a fixed time per operation.
`timescale 1ns/1ps
`default_nettype none
module fpe_busy_timer
	import fpe_pkg::*;
#(
	parameter int CW = 24
)
(
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          srst,
	// Control
	input  wire logic          start,
	input  wire logic [CW-1:0] load,
	output logic               done
);
	logic [CW-1:0] count_ff;
	logic          run_ff;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			count_ff <= '0;
			run_ff   <= 1'b0;
		end
		else if (start)
		begin
			count_ff <= load;
			run_ff   <= 1'b1;
		end
		else if (run_ff)
		begin
			if (count_ff <= CW'(1))
				run_ff <= 1'b0;
			count_ff <= count_ff - CW'(1);
		end
	end

	assign done = run_ff && (count_ff <= CW'(1));
endmodule : fpe_busy_timer
`default_nettype wire

// ==== hdl/fpe_flash_ctrl.sv ====
// Flash program/erase sequencer with AHB-Lite register slave and irq.
// Assumes the array accepts a one-cycle start strobe with address/data
// and that protection maps come from the system controller as levels.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_ctrl
	import fpe_pkg::*;
#(
	parameter int ERASE_TIME = ERASE_CYCLES,
	parameter int PROG_TIME  = PROG_CYCLES,
	parameter int BLOCKS     = 4,
	parameter int BLOCK_SHIFT = 11
)
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              srst,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// Protection maps
	input  wire logic [BLOCKS-1:0] read_protect_map,
	input  wire logic [BLOCKS-1:0] program_protect_map,
	// Flash array
	output logic                   flashEraseStb,
	output logic                   flashProgStb,
	output logic [31:0]            flashAddr,
	output logic [31:0]            flashWdata,
	// Interrupt
	output logic                   irq
);
	logic [31:0]  flash_addr_reg_ff;
	logic [31:0]  flash_wdata_reg_ff;
	logic [1:0]   rawIrq_ff;
	logic [1:0]   irqMask_ff;
	fpe_state_t   state_ff;
	logic         eraseStb_ff;
	logic         progStb_ff;
	logic         wrPend_ff;
	logic [11:0]  wrAddr_ff;
	logic [31:0]  hrdata_ff;
	logic         opDone;
	logic         start;
	logic [24:0]  loadVal;
	logic         isWrite;
	logic         isRead;
	logic [11:0]  rdAddr;
	logic         cmdWrite;
	logic         keyOk;
	logic         wantErase;
	logic         wantProg;
	logic         blockProt;
	logic         violation;
	logic [1:0]   maskedIrq;
	logic [1:0]   clearBits;
	logic [$clog2(BLOCKS)-1:0] blockIdx;

	function automatic logic [11:0] fpe_ofs(input logic [31:0] a);
		return {a[11:2], 2'b00};
	endfunction : fpe_ofs

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign isWrite   = hsel && hready && htrans[1] && hwrite;
	assign isRead    = hsel && hready && htrans[1] && !hwrite;
	assign rdAddr    = fpe_ofs(haddr);

	// Address phase captured; data phase acts one cycle later
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= '0;
		end
		else
		begin
			wrPend_ff <= isWrite;
			if (isWrite)
				wrAddr_ff <= rdAddr;
		end
	end

	// Command decode: key and exactly one bit, never while busy
	assign cmdWrite  = wrPend_ff && (wrAddr_ff == CMD_OFS);
	assign keyOk     = hwdata[31:16] == ACCESS_KEY; // R14
	assign wantErase = cmdWrite && keyOk && hwdata[ERASE_BIT]
		&& !hwdata[PROG_BIT] && (state_ff == ST_IDLE); // R01
	assign wantProg  = cmdWrite && keyOk && hwdata[PROG_BIT]
		&& !hwdata[ERASE_BIT] && (state_ff == ST_IDLE); // R05

	// Violation: program or erase into a block cleared in either map
	assign blockIdx  = flash_addr_reg_ff[BLOCK_SHIFT +: $clog2(BLOCKS)];
	assign blockProt = !program_protect_map[blockIdx]
		|| !read_protect_map[blockIdx];
	assign violation = (wantErase || wantProg) && blockProt; // R10
	assign start     = (wantErase || wantProg) && !blockProt;
	assign loadVal   = wantErase ? 25'(ERASE_TIME) : 25'(PROG_TIME);

	fpe_busy_timer #(
		.CW (25)
	) u_timer (
		.core_clk (core_clk),
		.srst     (srst),
		.start    (start),
		.load     (loadVal),
		.done     (opDone)
	);

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			flash_addr_reg_ff  <= REG_RESET;
			flash_wdata_reg_ff <= REG_RESET;
		end
		else if (wrPend_ff && state_ff == ST_IDLE)
		begin
			// Operands frozen while a cycle runs, so the array sees stable data
			if (wrAddr_ff == ADDR_OFS)
				flash_addr_reg_ff <= hwdata;
			if (wrAddr_ff == WDATA_OFS)
				flash_wdata_reg_ff <= hwdata;
		end
	end

	// Busy state; a zero write changes nothing
	always_ff @(posedge core_clk)
	begin
		if (srst)
			state_ff <= ST_IDLE;
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					if (start && wantErase)
						state_ff <= ST_ERASE; // R01
					else if (start)
						state_ff <= ST_PROG; // R05
				end
				ST_ERASE:
				begin
					if (opDone)
						state_ff <= ST_IDLE; // R04
				end
				ST_PROG:
				begin
					if (opDone)
						state_ff <= ST_IDLE; // R07
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			eraseStb_ff <= 1'b0;
			progStb_ff  <= 1'b0;
			flashAddr   <= REG_RESET;
			flashWdata  <= REG_RESET;
		end
		else
		begin
			eraseStb_ff <= start && wantErase;
			progStb_ff  <= start && wantProg;
			if (start)
			begin
				flashAddr  <= flash_addr_reg_ff;
				flashWdata <= flash_wdata_reg_ff; // R05
			end
		end
	end
	assign flashEraseStb = eraseStb_ff;
	assign flashProgStb  = progStb_ff;

	// Interrupt status: set wins over a same-cycle clear
	assign clearBits = (wrPend_ff && wrAddr_ff == MISC_OFS)
		? hwdata[1:0] : 2'b00;
	always_ff @(posedge core_clk)
	begin
		if (srst)
			rawIrq_ff <= IRQ_RESET;
		else
		begin
			if (clearBits[DONE_BIT] && maskedIrq[DONE_BIT])
				rawIrq_ff[DONE_BIT] <= 1'b0; // R13
			if (clearBits[VIOL_BIT] && maskedIrq[VIOL_BIT])
				rawIrq_ff[VIOL_BIT] <= 1'b0; // R13
			if (opDone && state_ff != ST_IDLE)
				rawIrq_ff[DONE_BIT] <= 1'b1; // R09
			if (violation)
				rawIrq_ff[VIOL_BIT] <= 1'b1; // R10
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			irqMask_ff <= IRQ_RESET;
		else if (wrPend_ff && wrAddr_ff == MASK_OFS)
			irqMask_ff <= hwdata[1:0]; // R11
	end

	assign maskedIrq = rawIrq_ff & irqMask_ff; // R12
	assign irq       = |maskedIrq; // R08 R16

	// Read mux; raw register is read-only, reserved bits zero
	always_ff @(posedge core_clk)
	begin
		if (srst)
			hrdata_ff <= REG_RESET;
		else if (isRead)
		begin
			case (rdAddr)
				ADDR_OFS:  hrdata_ff <= flash_addr_reg_ff;
				WDATA_OFS: hrdata_ff <= flash_wdata_reg_ff;
				CMD_OFS:   hrdata_ff <= {30'h0,
					state_ff == ST_ERASE, state_ff == ST_PROG}; // R03 R06
				RAW_OFS:   hrdata_ff <= {30'h0, rawIrq_ff}; // R16 R17
				MASK_OFS:  hrdata_ff <= {30'h0, irqMask_ff}; // R17
				MISC_OFS:  hrdata_ff <= {30'h0, maskedIrq}; // R12 R17
				default:   hrdata_ff <= REG_RESET;
			endcase
		end
	end

	logic unusedBits;
	assign unusedBits = ^{haddr[31:12], haddr[1:0], hsize, htrans[0],
		hwdata[15:2]};
endmodule : fpe_flash_ctrl
`default_nettype wire

// ==== testbench/fpe_flash_ctrl_asserts.sv ====
// Port checker for the flash command block.
// Assumes one clock domain and bind into fpe_flash_ctrl.
`timescale 1ns/1ps
`default_nettype none
module fpe_chk
	import fpe_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        srst,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Array and interrupt
	input wire logic        flashEraseStb,
	input wire logic        flashProgStb,
	input wire logic        irq
);
	logic wrAny_ff;
	logic wrCmd_ff;
	always_ff @(posedge core_clk)
	begin
		wrAny_ff <= !srst && hsel && hready && htrans[1] && hwrite;
		wrCmd_ff <= !srst && hsel && hready && htrans[1] && hwrite
			&& haddr[11:0] == CMD_OFS;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// Busy window is shorter than the smallest sim time of either op
	sequence quiet8;
		!(flashProgStb || flashEraseStb) [*8];
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_PROG_CAUSE: assert property (flashProgStb |-> $past(wrCmd_ff
		&& hwdata[31:16] == ACCESS_KEY && hwdata[1:0] == 2'h1))
		else $error("program strobe without keyed command");
	AST_ERASE_CAUSE: assert property (flashEraseStb |-> $past(wrCmd_ff
		&& hwdata[31:16] == ACCESS_KEY && hwdata[1:0] == 2'h2))
		else $error("erase strobe without keyed command");
	AST_PROG_BUSY: assert property (flashProgStb |=> quiet8)
		else $error("new strobe while program busy");
	AST_ERASE_BUSY: assert property (flashEraseStb |=> quiet8)
		else $error("new strobe while erase busy");
	AST_ONE_STB: assert property (!(flashProgStb && flashEraseStb))
		else $error("both strobes at once");
	AST_ZERO_CMD: assert property (wrCmd_ff && hwdata[1:0] == 2'h0
		|=> !flashProgStb && !flashEraseStb)
		else $error("zero command started an operation");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wrAny_ff))
		else $error("interrupt dropped without a write");
endmodule : fpe_chk
bind fpe_flash_ctrl fpe_chk u_chk (.core_clk(core_clk), .srst(srst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .flashEraseStb(flashEraseStb),
	.flashProgStb(flashProgStb), .irq(irq));
`default_nettype wire

// ==== testbench/fpe_flash_model.sv ====
// Behavioural flash array: records the last operation it was given.
// Assumes one-cycle strobes with address and data valid alongside.
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model
(
	// Clock and reset
	input wire logic         core_clk,
	input wire logic         srst,
	// From the controller
	input wire logic         flashEraseStb,
	input wire logic         flashProgStb,
	input wire logic [31:0]  flashAddr,
	input wire logic [31:0]  flashWdata,
	// Observation
	output logic [31:0]      lastAddr_ff,
	output logic [31:0]      lastData_ff,
	output logic [7:0]       opCnt_ff
);
	always_ff @(posedge core_clk)
	begin
		if (srst)
			opCnt_ff <= 8'h0;
		else if (flashProgStb || flashEraseStb)
		begin
			lastAddr_ff <= flashAddr;
			// Erased cells read all ones
			lastData_ff <= flashProgStb ? flashWdata : 32'hffffffff;
			opCnt_ff    <= opCnt_ff + 8'h1;
		end
	end
endmodule : fpe_flash_model
`default_nettype wire

// ==== testbench/flash_program_erase_ctrl_tb.sv ====
// Register-level bench of the flash command block over AHB-Lite.
// Assumes a zero-wait slave and shortened operation times.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin nMismatch++; \
	$display("Error at %0t: %h vs %h", $time, a, e); end end
module flash_program_erase_ctrl_tb;
	import fpe_pkg::*;
	localparam int PT = 10;
	localparam int ET = 20;
	logic        core_clk = 1'h0, srst = 1'h1, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, fA, fD, mA, mD;
	logic [1:0]  htrans = 2'h0;
	logic [3:0]  pgMap = 4'hf;
	logic        hready, hresp, eStb, pStb, irq;
	logic [7:0]  nOps;
	int          nMismatch = 0, numChecks = 0;
	fpe_flash_ctrl #(.ERASE_TIME(ET), .PROG_TIME(PT)) dut (
		.core_clk(core_clk), .srst(srst), .hsel(1'h1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.read_protect_map(4'hf), .program_protect_map(pgMap),
		.flashEraseStb(eStb), .flashProgStb(pStb), .flashAddr(fA),
		.flashWdata(fD), .irq(irq));
	fpe_flash_model u_flash (.core_clk(core_clk), .srst(srst),
		.flashEraseStb(eStb), .flashProgStb(pStb), .flashAddr(fA),
		.flashWdata(fD), .lastAddr_ff(mA), .lastData_ff(mD), .opCnt_ff(nOps));
	initial forever #2.5 core_clk = ~core_clk;
	task finish_test;
		$display("checks %0d mismatches %0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {20'h0, a};
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (hready !== 1'b1) @(posedge core_clk);
		rd = hrdata;
	endtask : xfer
	task chk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : chk
	initial
	begin
		repeat (20) @(posedge core_clk);
		srst <= 1'h0;
		chk(RAW_OFS, 32'h0);
		chk(MASK_OFS, 32'h0);
		chk(MISC_OFS, 32'h0);
		xfer(1'b1, RAW_OFS, 32'hffffffff);
		chk(RAW_OFS, 32'h0);
		xfer(1'b1, 12'h020, 32'h5);
		chk(12'h020, 32'h0);
		xfer(1'b1, MASK_OFS, 32'hffffffff);
		chk(MASK_OFS, 32'h3);
		$display("register test done");
		xfer(1'b1, WDATA_OFS, 32'h1234abcd);
		xfer(1'b1, ADDR_OFS, 32'h104);
		xfer(1'b1, CMD_OFS, 32'ha4420001);
		chk(CMD_OFS, 32'h1);
		`CHK({mA, mD}, {32'h104, 32'h1234abcd})
		repeat (PT) @(posedge core_clk);
		chk(CMD_OFS, 32'h0);
		chk(RAW_OFS, 32'h2);
		chk(MISC_OFS, 32'h2);
		`CHK(irq, 1'b1)
		xfer(1'b1, MISC_OFS, 32'h0);
		chk(RAW_OFS, 32'h2);
		xfer(1'b1, MISC_OFS, 32'h2);
		chk(RAW_OFS, 32'h0);
		`CHK(irq, 1'b0)
		$display("program test done");
		xfer(1'b1, MASK_OFS, 32'h0);
		xfer(1'b1, ADDR_OFS, 32'h800);
		xfer(1'b1, CMD_OFS, 32'ha4420002);
		xfer(1'b1, CMD_OFS, 32'ha4420000);
		chk(CMD_OFS, 32'h2);
		`CHK(mA, 32'h800)
		repeat (ET) @(posedge core_clk);
		chk(CMD_OFS, 32'h0);
		chk(MISC_OFS, 32'h0);
		`CHK(irq, 1'b0)
		xfer(1'b1, MASK_OFS, 32'h2);
		chk(MISC_OFS, 32'h2);
		`CHK(irq, 1'b1)
		xfer(1'b1, MISC_OFS, 32'h2);
		$display("erase test done");
		xfer(1'b1, MASK_OFS, 32'h1);
		pgMap <= 4'he;
		xfer(1'b1, ADDR_OFS, 32'h0);
		// A command with the wrong key is dropped silently
		xfer(1'b1, CMD_OFS, 32'h12340001);
		chk(RAW_OFS, 32'h0);
		`CHK(nOps, 8'h2)
		xfer(1'b1, CMD_OFS, 32'ha4420001);
		chk(RAW_OFS, 32'h1);
		`CHK(nOps, 8'h2)
		`CHK(irq, 1'b1)
		xfer(1'b1, MISC_OFS, 32'h1);
		chk(MISC_OFS, 32'h0);
		$display("violation test done");
		finish_test;
	end
	initial
	begin
		repeat (2000) @(posedge core_clk);
		nMismatch++;
		finish_test;
	end
endmodule : flash_program_erase_ctrl_tb
`default_nettype wire
